// ==== src/reset_and_supply_monitor.sv ====
// Operation
// - Reset halts core, resets registers, forces ports, disables interrupts and timers.
// - RAM is never cleared by reset; stack pointer reinitialised by core reset.
// - During reset port latches are all ones, open drain, weak pull-ups on.
// - Supply-monitor and power-on resets drive the reset pin low.
// - On reset exit program counter is zero and internal oscillator selected.
// - On any reset exit watchdog enabled, clocked from system clock over twelve.
// - Power-up holds reset until above threshold, then waits power-on delay.
// - Power-on and power-fail resets set power-on flag; all other resets clear it.
// - Power-on monitor runs in sleep unless disabled; disabled means software, flash-error and pin resets are full.
// - After power-on or power-fail reset, digital monitor on and selected, analog off.
// - Selected monitor below reset threshold holds core and pin in reset.
// - After power-fail reset flag reads one, RAM invalid, digital monitor selected.
// - Monitor enable and selection are reset only by power-on and power-fail resets.
// - Sleep disables power-fail reset and monitors; wake restores software settings.
// - Early-warning ok flag clears at warning threshold; interrupt when enabled.
// - Flash write or erase with digital monitor disabled causes flash-error reset.
// - Supply-monitor reset releases without the power-on delay.
// - Software enables monitor, optionally waits, then selects it as reset source.
// - Control register at address 0xff on every page; defined reset values.
// - Status bits read zero at or below threshold, one above.
// - Writing the power-on flag bit deselects or selects digital monitor.
`timescale 1ns/1ps
module reset_and_supply_monitor
  import rst_supply_pkg::*;
#(
  parameter int POR_LOW_CYC = POR_DELAY_LOW_CYC,
  parameter int POR_HIGH_CYC = POR_DELAY_HIGH_CYC
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  // Comparator levels (asynchronous)
  input wire logic por_above,
  input wire logic supply_high,
  input wire logic dig_above_reset,
  input wire logic dig_above_warn,
  input wire logic ana_above_reset,
  input wire logic ana_above_warn,
  // Other reset requests from the core side
  input wire logic sys_reset_req,
  input wire logic flash_wr_req,
  input wire logic sleep_mode,
  input wire logic por_monitor_disable,
  // Register access
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic power_on_flag_wr,
  input wire logic power_on_flag_wdata,
  output logic [7:0] supply_monitor_ctrl,
  output logic power_on_flag,
  // Reset pin, active low, open drain
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe_n,
  // Core side reset outputs
  output logic core_reset,
  output logic flash_error_reset,
  output logic [15:0] pc_reset_value,
  output logic int_osc_select,
  output logic wdt_enable,
  output logic [3:0] wdt_clk_div,
  output logic [7:0] port_latch,
  output logic port_open_drain,
  output logic weak_pullup_en,
  output logic ram_clear,
  // Early warning interrupts
  output logic dig_early_irq,
  output logic ana_early_irq
);

  // Synchronisers for comparator and pin levels
  localparam int NS = 7;
  logic [NS-1:0] s1_q, s1_d, s2_q, s2_d;
  logic por_ok, high_v, dig_st, dig_wk, ana_st, ana_wk, pin_lo;
  always_comb begin
    s1_d = {~rst_pin_in, ana_above_warn, ana_above_reset, dig_above_warn,
            dig_above_reset, supply_high, por_above};
    s2_d = s1_q;
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      s1_q <= '0;
      s2_q <= '0;
    end else if (clk_en) begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end
  assign {pin_lo, ana_wk, ana_st, dig_wk, dig_st, high_v, por_ok} = s2_q;

  // Control register and sequencer state
  seq_state_e st_q, st_d;
  logic [31:0] cnt_q, cnt_d;
  logic dig_en_q, dig_en_d, ana_en_q, ana_en_d;
  logic dig_ie_q, dig_ie_d, ana_ie_q, ana_ie_d;
  logic dig_sel_q, dig_sel_d, pof_q, pof_d;
  logic drive_pin_q, drive_pin_d, ferr_q, ferr_d;
  logic pfail, por_drop, full_por, ctrl_wr;
  logic [1:0] drv_hist_q, drv_hist_d;
  logic ext_pin;

  // Own pin drive echoes through the synchroniser; mask it for two cycles after release
  always_comb begin
    drv_hist_d = {drv_hist_q[0], drive_pin_q};
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      drv_hist_q <= 2'b11;
    end else if (clk_en) begin
      drv_hist_q <= drv_hist_d;
    end
  end
  assign ext_pin = pin_lo & ~drive_pin_q & ~(|drv_hist_q);

  // Monitors off in sleep; software settings kept in the registers
  assign pfail = ~sleep_mode & dig_en_q & dig_sel_q & ~dig_st;
  assign por_drop = ~por_ok;
  // Software, flash-error and pin resets become full power-on reset while the monitor is disabled
  assign full_por = por_monitor_disable & (sys_reset_req | ferr_q | ext_pin);
  assign ctrl_wr = reg_wr & (reg_addr == SUPPLY_MONITOR_CONTROL_ADDR);

  // Next-state logic for sequencer and registers
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    dig_en_d = dig_en_q;
    ana_en_d = ana_en_q;
    dig_ie_d = dig_ie_q;
    ana_ie_d = ana_ie_q;
    dig_sel_d = dig_sel_q;
    pof_d = pof_q;
    drive_pin_d = drive_pin_q;
    ferr_d = 1'b0;
    if (st_q == ST_RUN && ctrl_wr) begin
      dig_en_d = reg_wdata[DIG_EN_BIT];
      dig_ie_d = reg_wdata[DIG_IE_BIT];
      ana_en_d = reg_wdata[ANA_EN_BIT];
      ana_ie_d = reg_wdata[ANA_IE_BIT];
    end
    if (st_q == ST_RUN && power_on_flag_wr) begin
      dig_sel_d = power_on_flag_wdata;
    end
    if (st_q == ST_RUN && flash_wr_req && !dig_en_q) begin
      ferr_d = 1'b1;
    end
    case (st_q)
      ST_POR_HOLD: begin
        drive_pin_d = 1'b1;
        cnt_d = '0;
        if (por_ok) begin
          st_d = ST_POR_WAIT;
        end
      end
      ST_POR_WAIT: begin
        drive_pin_d = 1'b1;
        cnt_d = cnt_q + 32'd1;
        if (!por_ok) begin
          st_d = ST_POR_HOLD;
        end else if (cnt_q >= 32'(high_v ? POR_HIGH_CYC : POR_LOW_CYC) - 32'd1) begin
          st_d = ST_RUN;
          drive_pin_d = 1'b0;
        end
      end
      ST_RUN: begin
        if (por_drop || full_por) begin
          st_d = ST_POR_HOLD;
        end else if (pfail) begin
          st_d = ST_SYS_RST;
          drive_pin_d = 1'b1;
          pof_d = 1'b1;
        end else if (sys_reset_req || ferr_q || ext_pin) begin
          st_d = ST_SYS_RST;
          pof_d = 1'b0;
        end
      end
      ST_SYS_RST: begin
        if (por_drop) begin
          st_d = ST_POR_HOLD;
        end else if (drive_pin_q) begin
          if (dig_st) begin
            st_d = ST_RUN;
            drive_pin_d = 1'b0;
            dig_en_d = DIG_EN_RESET;
            dig_sel_d = DIG_SEL_RESET;
            ana_en_d = ANA_EN_RESET;
            dig_ie_d = DIG_IE_RESET;
            ana_ie_d = ANA_IE_RESET;
          end
        end else if (!sys_reset_req && !ext_pin) begin
          st_d = ST_RUN;
          dig_ie_d = DIG_IE_RESET;
          ana_ie_d = ANA_IE_RESET;
        end
      end
      default: begin
        st_d = ST_POR_HOLD;
      end
    endcase
    if (st_d == ST_POR_HOLD) begin
      pof_d = 1'b1;
      dig_en_d = DIG_EN_RESET;
      dig_sel_d = DIG_SEL_RESET;
      ana_en_d = ANA_EN_RESET;
      dig_ie_d = DIG_IE_RESET;
      ana_ie_d = ANA_IE_RESET;
      drive_pin_d = 1'b1;
    end
  end

  // State registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_q <= ST_POR_HOLD;
      cnt_q <= '0;
      dig_en_q <= DIG_EN_RESET;
      ana_en_q <= ANA_EN_RESET;
      dig_ie_q <= DIG_IE_RESET;
      ana_ie_q <= ANA_IE_RESET;
      dig_sel_q <= DIG_SEL_RESET;
      pof_q <= 1'b1;
      drive_pin_q <= 1'b1;
      ferr_q <= 1'b0;
    end else if (clk_en) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      dig_en_q <= dig_en_d;
      ana_en_q <= ana_en_d;
      dig_ie_q <= dig_ie_d;
      ana_ie_q <= ana_ie_d;
      dig_sel_q <= dig_sel_d;
      pof_q <= pof_d;
      drive_pin_q <= drive_pin_d;
      ferr_q <= ferr_d;
    end
  end

  // Readback: status bits track the synchronised comparators
  always_comb begin
    supply_monitor_ctrl = 8'h00;
    supply_monitor_ctrl[DIG_EN_BIT] = dig_en_q;
    supply_monitor_ctrl[DIG_STAT_BIT] = dig_st;
    supply_monitor_ctrl[DIG_OK_BIT] = dig_wk;
    supply_monitor_ctrl[DIG_IE_BIT] = dig_ie_q;
    supply_monitor_ctrl[ANA_EN_BIT] = ana_en_q;
    supply_monitor_ctrl[ANA_STAT_BIT] = ana_st;
    supply_monitor_ctrl[ANA_OK_BIT] = ana_wk;
    supply_monitor_ctrl[ANA_IE_BIT] = ana_ie_q;
  end
  assign power_on_flag = pof_q;

  // Reset outputs toward core and pins
  assign core_reset = (st_q != ST_RUN);
  assign rst_pin_out = 1'b0;
  assign rst_pin_oe_n = ~drive_pin_q;
  assign flash_error_reset = ferr_q;
  assign pc_reset_value = PC_RESET;
  assign int_osc_select = core_reset;
  assign wdt_enable = core_reset;
  assign wdt_clk_div = WDT_DIV_RESET;
  assign port_latch = PORT_LATCH_RESET;
  assign port_open_drain = core_reset;
  assign weak_pullup_en = 1'b1;
  assign ram_clear = 1'b0;

  // Early-warning interrupt levels, gated off in sleep
  assign dig_early_irq = dig_ie_q & dig_en_q & ~sleep_mode & ~dig_wk;
  assign ana_early_irq = ana_ie_q & ana_en_q & ~sleep_mode & ~ana_wk;

endmodule

// ==== src/rst_supply_pkg.sv ====
package rst_supply_pkg;
  // Register address and control-register field positions
  localparam logic [7:0] SUPPLY_MONITOR_CONTROL_ADDR = 8'hff;
  localparam int DIG_EN_BIT = 7;
  localparam int DIG_STAT_BIT = 6;
  localparam int DIG_OK_BIT = 5;
  localparam int DIG_IE_BIT = 4;
  localparam int ANA_EN_BIT = 3;
  localparam int ANA_STAT_BIT = 2;
  localparam int ANA_OK_BIT = 1;
  localparam int ANA_IE_BIT = 0;
  // Reset values of the writable control bits
  localparam logic DIG_EN_RESET = 1'b1;
  localparam logic DIG_IE_RESET = 1'b0;
  localparam logic ANA_EN_RESET = 1'b0;
  localparam logic ANA_IE_RESET = 1'b0;
  localparam logic DIG_SEL_RESET = 1'b1;
  // Port latch and core defaults
  localparam logic [7:0] PORT_LATCH_RESET = 8'hff;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [3:0] WDT_DIV_RESET = 4'hc;
  // Power-on delay
  localparam int POR_DELAY_LOW_MS = 7;
  localparam int POR_DELAY_HIGH_MS = 15;
  localparam int CLK_KHZ = 125000;
  localparam int POR_DELAY_LOW_CYC = POR_DELAY_LOW_MS * CLK_KHZ;
  localparam int POR_DELAY_HIGH_CYC = POR_DELAY_HIGH_MS * CLK_KHZ;
  // Sequencer states
  typedef enum logic [3:0] {
    ST_POR_HOLD = 4'b0001,
    ST_POR_WAIT = 4'b0010,
    ST_RUN      = 4'b0100,
    ST_SYS_RST  = 4'b1000
  } seq_state_e;
endpackage

// ==== test/core_side_model.sv ====
`timescale 1ns/1ps
module core_side_model (
  // Clock and commands
  input wire logic mclk,
  input wire logic sw_sel,
  input wire logic ext_low,
  // Reset pin from the device
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe_n,
  // Software write and pin level
  output logic power_on_flag_wr = 1'b0,
  output logic power_on_flag_wdata,
  output logic rst_pin_in
);
  // Software always keeps the monitor selected, after enabling it
  assign power_on_flag_wdata = 1'b1;
  always @(posedge mclk) power_on_flag_wr <= sw_sel;
  // Open-drain pin with pull-up
  assign rst_pin_in = ((!rst_pin_oe_n && !rst_pin_out) || ext_low) ? 1'b0 : 1'b1;
endmodule

// ==== test/reset_and_supply_monitor_sva.sv ====
`timescale 1ns/1ps
module rsm_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Requests
  input wire logic clk_en,
  input wire logic sleep_mode,
  input wire logic sys_reset_req,
  input wire logic flash_wr_req,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  // Results
  input wire logic [7:0] supply_monitor_ctrl,
  input wire logic power_on_flag,
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe_n,
  input wire logic core_reset,
  input wire logic flash_error_reset,
  input wire logic [7:0] port_latch,
  input wire logic int_osc_select,
  input wire logic dig_early_irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // Pin, core and register relations
  AST_PIN_LOW: assert property (rst_pin_out == 1'b0) else $error("pin level not low");
  AST_PIN_CORE: assert property (!rst_pin_oe_n |-> core_reset) else $error("pin driven in run");
  AST_PORT: assert property (core_reset |-> port_latch == 8'hff && int_osc_select) else $error("defaults");
  AST_FLAG: assert property (!rst_pin_oe_n ##1 !rst_pin_oe_n |-> power_on_flag) else $error("flag low");
  AST_IRQ: assert property (!sleep_mode [*3] |-> dig_early_irq == (supply_monitor_ctrl[4] &&
    supply_monitor_ctrl[7] && !supply_monitor_ctrl[5])) else $error("irq level");
  AST_WR: assert property (reg_wr && reg_addr == 8'hff && clk_en && !core_reset && !sys_reset_req
    |=> supply_monitor_ctrl[4:3] == $past(reg_wdata[4:3])) else $error("write lost");
  AST_FLASH: assert property (flash_wr_req && clk_en && !core_reset && !supply_monitor_ctrl[7]
    |-> ##[1:3] flash_error_reset) else $error("no flash reset");
  AST_SYS: assert property (sys_reset_req && clk_en |-> ##[0:4] core_reset) else $error("no reset");
endmodule
bind reset_and_supply_monitor rsm_checker chk_u (.mclk, .reset, .clk_en, .sleep_mode, .sys_reset_req,
  .flash_wr_req, .reg_wr, .reg_addr, .reg_wdata, .supply_monitor_ctrl, .power_on_flag, .rst_pin_out,
  .rst_pin_oe_n, .core_reset, .flash_error_reset, .port_latch, .int_osc_select, .dig_early_irq);

// ==== test/test_reset_and_supply_monitor.sv ====
`timescale 1ns/1ps
module test_reset_and_supply_monitor;
  import rst_supply_pkg::*;
  localparam int LOW = 10;
  logic mclk = 0, reset = 1, clk_en = 1, por_above = 1, supply_high = 0, dig_above_reset = 1;
  logic dig_above_warn = 1, ana_above_reset = 1, ana_above_warn = 1, sys_reset_req = 0, flash_wr_req = 0;
  logic sleep_mode = 0, por_monitor_disable = 0, reg_wr = 0, sw_sel = 0, ext_low = 0, seen;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, ctrl, port_latch;
  logic power_on_flag_wr, power_on_flag_wdata, power_on_flag, rst_pin_in, rst_pin_out, rst_pin_oe_n;
  logic core_reset, flash_error_reset, int_osc_select, wdt_enable, port_open_drain, weak_pullup_en;
  logic ram_clear, dig_early_irq, ana_early_irq;
  logic [15:0] pc_reset_value;
  logic [3:0] wdt_clk_div;
  int err_count = 0, total_checks = 0, cyc = 0, n;
  reset_and_supply_monitor #(.POR_LOW_CYC(LOW), .POR_HIGH_CYC(20)) dut_u (.mclk, .reset, .clk_en,
    .por_above, .supply_high, .dig_above_reset, .dig_above_warn, .ana_above_reset, .ana_above_warn,
    .sys_reset_req, .flash_wr_req, .sleep_mode, .por_monitor_disable, .reg_wr, .reg_addr, .reg_wdata,
    .power_on_flag_wr, .power_on_flag_wdata, .supply_monitor_ctrl(ctrl), .power_on_flag, .rst_pin_in,
    .rst_pin_out, .rst_pin_oe_n, .core_reset, .flash_error_reset, .pc_reset_value, .int_osc_select,
    .wdt_enable, .wdt_clk_div, .port_latch, .port_open_drain, .weak_pullup_en, .ram_clear,
    .dig_early_irq, .ana_early_irq);
  core_side_model far_u (.mclk, .sw_sel, .ext_low, .rst_pin_out, .rst_pin_oe_n, .power_on_flag_wr,
    .power_on_flag_wdata, .rst_pin_in);
  // Clock and hang limit
  initial forever #4 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      give_verdict();
    end
  end
  // Compare one value
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Closing report
  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Wait for core reset level, counting cycles
  task automatic wait_core(input logic lvl);
    n = 0;
    while (core_reset !== lvl && n < 100) begin
      @(negedge mclk);
      n++;
    end
    if (core_reset !== lvl) begin
      err_count++;
      $display("BAD core_reset wait expected %h seen %h", lvl, core_reset);
    end
  endtask
  // Control register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 0;
    repeat (2) @(negedge mclk);
  endtask
  // Power-up, delay and defaults
  task automatic t_por;
    repeat (3) @(posedge mclk);
    reset <= 0;
    @(negedge mclk);
    chk("oe_n", 0, rst_pin_oe_n);
    chk("ctrl", 8'h80, ctrl & 8'h99);
    chk("wdt", 16'h0003, {wdt_clk_div == 4'hc, wdt_enable});
    wait_core(0);
    chk("delay", 1, n >= LOW);
    chk("flag", 1, power_on_flag);
    chk("pc", 16'h0000, pc_reset_value);
    chk("pins", 16'h00ff, {ram_clear, weak_pullup_en, port_latch} ^ 16'h0100);
    chk("stat", 8'h60, ctrl & 8'h60);
  endtask
  // Writes, unmapped address and early warning
  task automatic t_reg;
    wr(8'hff, 8'h19);
    chk("ctrl", 8'h19, ctrl & 8'h99);
    wr(8'hfe, 8'h80);
    chk("ctrl", 8'h19, ctrl & 8'h99);
    wr(8'hff, 8'h99);
    dig_above_warn <= 0;
    repeat (4) @(negedge mclk);
    chk("ok", 0, ctrl[5]);
    chk("irq", 1, dig_early_irq);
    wr(8'hff, 8'h88);
    chk("irq", 0, dig_early_irq);
    dig_above_warn <= 1;
  endtask
  // Power fail, sleep and software reset
  task automatic t_fail;
    sw_sel <= 1;
    @(posedge mclk);
    sw_sel <= 0;
    dig_above_reset <= 0;
    wait_core(1);
    chk("oe_n", 0, rst_pin_oe_n);
    repeat (10) @(negedge mclk);
    chk("held", 1, core_reset);
    dig_above_reset <= 1;
    wait_core(0);
    chk("fast", 1, n < LOW);
    chk("flag", 1, power_on_flag);
    chk("ctrl", 8'h80, ctrl & 8'h89);
    sleep_mode <= 1;
    dig_above_reset <= 0;
    repeat (8) @(negedge mclk);
    chk("sleep", 0, core_reset);
    dig_above_reset <= 1;
    repeat (4) @(negedge mclk);
    sleep_mode <= 0;
    wr(8'hff, 8'h08);
    sys_reset_req <= 1;
    wait_core(1);
    chk("oe_n", 1, rst_pin_oe_n);
    sys_reset_req <= 0;
    wait_core(0);
    chk("flag", 0, power_on_flag);
    chk("keep", 8'h08, ctrl & 8'h88);
  endtask
  // Flash error and disabled power-on monitor
  task automatic t_flash;
    flash_wr_req <= 1;
    @(posedge mclk);
    flash_wr_req <= 0;
    seen = 0;
    repeat (4) @(negedge mclk) seen |= flash_error_reset;
    chk("ferr", 1, seen);
    wait_core(0);
    por_monitor_disable <= 1;
    sys_reset_req <= 1;
    wait_core(1);
    sys_reset_req <= 0;
    wait_core(0);
    chk("full", 1, n >= LOW && power_on_flag);
  endtask
  // Main sequence
  initial begin
    t_por();
    t_reg();
    t_fail();
    t_flash();
    give_verdict();
  end
endmodule
